// file: rtl/mdb_pkg.sv
// constants for the peripheral module disable bank
package mdb_pkg;

	// ------------------------------------------------------------
	// register bus geometry
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;
	localparam logic [ADDR_W-1:0] ADDR_CTRL_A = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_CTRL_B = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_CTRL_C = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_CTRL_D = 4'h3;
	localparam logic [DATA_W-1:0] RESET_VALUE = 16'h0000;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 16'h0000;

	// ------------------------------------------------------------
	// implemented bit masks
	// ------------------------------------------------------------
	// base bits of control a: timers 15..11, serial units 7..3, adc 0
	localparam logic [DATA_W-1:0] MASK_A_BASE = 16'hF8F9;
	// motor-control variant bits: quad decoder 10, motor pwm 9
	localparam logic [DATA_W-1:0] MASK_A_MOTOR = 16'h0600;
	// can variant bit 1
	localparam logic [DATA_W-1:0] MASK_A_CAN = 16'h0002;
	localparam logic [DATA_W-1:0] MASK_B = 16'h0F0F;
	localparam logic [DATA_W-1:0] MASK_C = 16'h0482;
	localparam logic [DATA_W-1:0] MASK_D = 16'h000C;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned TIMER_FIVE_OFF = 15;
	localparam int unsigned TIMER_FOUR_OFF = 14;
	localparam int unsigned TIMER_THREE_OFF = 13;
	localparam int unsigned TIMER_TWO_OFF = 12;
	localparam int unsigned TIMER_ONE_OFF = 11;
	localparam int unsigned QUAD_DECODER_OFF = 10;
	localparam int unsigned MOTOR_PWM_OFF = 9;
	localparam int unsigned I2C_FIRST_OFF = 7;
	localparam int unsigned UART_SECOND_OFF = 6;
	localparam int unsigned UART_FIRST_OFF = 5;
	localparam int unsigned SPI_SECOND_OFF = 4;
	localparam int unsigned SPI_FIRST_OFF = 3;
	localparam int unsigned CAN_CTRL_OFF = 1;
	localparam int unsigned ADC_OFF = 0;
	localparam int unsigned CAPTURE_FOUR_OFF = 11;
	localparam int unsigned CAPTURE_THREE_OFF = 10;
	localparam int unsigned CAPTURE_TWO_OFF = 9;
	localparam int unsigned CAPTURE_ONE_OFF = 8;
	localparam int unsigned COMPARE_FOUR_OFF = 3;
	localparam int unsigned COMPARE_THREE_OFF = 2;
	localparam int unsigned COMPARE_TWO_OFF = 1;
	localparam int unsigned COMPARE_ONE_OFF = 0;
	localparam int unsigned COMPARATOR_OFF = 10;
	localparam int unsigned CRC_ENGINE_OFF = 7;
	localparam int unsigned I2C_SECOND_OFF = 1;
	localparam int unsigned REF_CLOCK_OUT_OFF = 3;
	localparam int unsigned CHARGE_TIME_UNIT_OFF = 2;

	// lsb of each register inside the flat enable vector
	localparam int unsigned LSB_A = 0;
	localparam int unsigned LSB_B = 16;
	localparam int unsigned LSB_C = 32;
	localparam int unsigned LSB_D = 48;
	localparam int unsigned EN_W = 64;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned INSTR_CYCLE_NS = 20;
	// settle delay rounds up, never below one clock
	localparam int unsigned INSTR_CYCLE_CLKS = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : mdb_pkg

// file: rtl/mdb_en_stage.sv
// delay line that retimes peripheral enables by one instruction cycle
`timescale 1ns/10ps
module mdb_en_stage #(
	parameter int unsigned WIDTH = mdb_pkg::EN_W,
	parameter int unsigned STAGES = mdb_pkg::INSTR_CYCLE_CLKS
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	// enables in and retimed enables out
	input wire logic [WIDTH-1:0] en_in,
	output logic [WIDTH-1:0] en_out
);

	// ------------------------------------------------------------
	// pipeline storage
	// ------------------------------------------------------------
	logic [WIDTH-1:0] pipe_r [STAGES];
	logic [WIDTH-1:0] pipe_nxt [STAGES];

	// shift by one slot per enabled clock, hold while ce is low
	always_comb
	begin
		for (int i = 0; i < STAGES; i++)
		begin
			if (!ce)
				pipe_nxt[i] = pipe_r[i];
			else if (i == 0)
				pipe_nxt[i] = en_in;
			else
				pipe_nxt[i] = pipe_r[i-1];
		end
	end

	// reset to all ones: peripherals start enabled
	always_ff @(posedge mclk)
	begin
		for (int i = 0; i < STAGES; i++)
		begin
			if (!rst_n)
				pipe_r[i] <= {WIDTH{1'b1}};
			else
				pipe_r[i] <= pipe_nxt[i];
		end
	end

	assign en_out = pipe_r[STAGES-1];

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// enable follows input after one stage
	stage_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(STAGES == 1 && ce) |=> en_out == $past(en_in))
		else $error("enable stage did not follow input");

endmodule : mdb_en_stage

// file: rtl/mdb_bank.sv
// peripheral module disable register bank with retimed enables
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/10ps

// Notes on behaviour
// - control a bits 15..11 switch off timers five down to one
// - control a bit 10 quad decoder, bit 9 motor pwm, motor variants only
// - control a bits 7..3: i2c one, uart two, uart one, spi two, spi one
// - control a bit 1 can controller on some variants, bit 0 the adc
// - control a bits 8 and 2 read zero, writes ignored
// - control b bits 11..8 switch off capture channels four down to one
// - control b bits 3..0 switch off compare channels four down to one
// - unlisted bits in control b, c, d read zero
// - control c bit 10 switches off the comparator
// - control c bit 7 crc engine, bit 1 second i2c
// - control d bit 3 reference clock output, bit 2 charge time unit
// - implemented bits read and write, clear at reset so all start enabled
// - enable changes one instruction cycle after its bit changes
// - disabled peripheral loses clocks and register access via its enable
module mdb_bank #(
	parameter bit HAS_MOTOR_CTRL = 1'b1,
	parameter bit HAS_CAN = 1'b1
) (
	// clock, reset, freeze
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	// register port
	input wire logic [mdb_pkg::ADDR_W-1:0] addr,
	input wire logic [mdb_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [mdb_pkg::DATA_W-1:0] rd_data,
	// timer enables
	output logic timer_five_en,
	output logic timer_four_en,
	output logic timer_three_en,
	output logic timer_two_en,
	output logic timer_one_en,
	// motor-control enables
	output logic quad_decoder_en,
	output logic motor_pwm_en,
	// serial unit enables
	output logic i2c_first_en,
	output logic uart_second_en,
	output logic uart_first_en,
	output logic spi_second_en,
	output logic spi_first_en,
	output logic can_ctrl_en,
	output logic i2c_second_en,
	// analog and misc enables
	output logic adc_en,
	output logic comparator_en,
	output logic crc_engine_en,
	output logic ref_clock_out_en,
	output logic charge_time_unit_en,
	// capture and compare enables
	output logic capture_four_en,
	output logic capture_three_en,
	output logic capture_two_en,
	output logic capture_one_en,
	output logic compare_four_en,
	output logic compare_three_en,
	output logic compare_two_en,
	output logic compare_one_en
);

	// ------------------------------------------------------------
	// implemented masks per variant
	// ------------------------------------------------------------
	localparam logic [mdb_pkg::DATA_W-1:0] MASK_A = mdb_pkg::MASK_A_BASE
		| (HAS_MOTOR_CTRL ? mdb_pkg::MASK_A_MOTOR : mdb_pkg::RESET_VALUE)
		| (HAS_CAN ? mdb_pkg::MASK_A_CAN : mdb_pkg::RESET_VALUE);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// write with unimplemented bits dropped, so they always read zero
	function automatic logic [mdb_pkg::DATA_W-1:0] mdb_store(
		input logic [mdb_pkg::DATA_W-1:0] held,
		input logic hit,
		input logic [mdb_pkg::DATA_W-1:0] data,
		input logic [mdb_pkg::DATA_W-1:0] mask
	);
		mdb_store = hit ? (data & mask) : held;
	endfunction : mdb_store

	// address match used by the write decode; the read port decodes with its own case
	function automatic logic mdb_hit(
		input logic [mdb_pkg::ADDR_W-1:0] a,
		input logic [mdb_pkg::ADDR_W-1:0] target
	);
		mdb_hit = (a == target);
	endfunction : mdb_hit

	// ------------------------------------------------------------
	// disable registers
	// ------------------------------------------------------------
	logic [mdb_pkg::DATA_W-1:0] ctrl_a_r;
	logic [mdb_pkg::DATA_W-1:0] ctrl_b_r;
	logic [mdb_pkg::DATA_W-1:0] ctrl_c_r;
	logic [mdb_pkg::DATA_W-1:0] ctrl_d_r;
	logic [mdb_pkg::DATA_W-1:0] ctrl_a_nxt;
	logic [mdb_pkg::DATA_W-1:0] ctrl_b_nxt;
	logic [mdb_pkg::DATA_W-1:0] ctrl_c_nxt;
	logic [mdb_pkg::DATA_W-1:0] ctrl_d_nxt;
	logic wr_go;

	// write decode; ce low freezes every register
	// reserved bits masked off
	always_comb
	begin
		wr_go = ce && wr_stb;
		ctrl_a_nxt = mdb_store(ctrl_a_r, wr_go && mdb_hit(addr, mdb_pkg::ADDR_CTRL_A), wr_data, MASK_A);
		ctrl_b_nxt = mdb_store(ctrl_b_r, wr_go && mdb_hit(addr, mdb_pkg::ADDR_CTRL_B), wr_data, mdb_pkg::MASK_B);
		ctrl_c_nxt = mdb_store(ctrl_c_r, wr_go && mdb_hit(addr, mdb_pkg::ADDR_CTRL_C), wr_data, mdb_pkg::MASK_C);
		// reference clock and charge unit bits stored
		ctrl_d_nxt = mdb_store(ctrl_d_r, wr_go && mdb_hit(addr, mdb_pkg::ADDR_CTRL_D), wr_data, mdb_pkg::MASK_D);
	end

	// all disable bits clear at reset
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			ctrl_a_r <= mdb_pkg::RESET_VALUE;
			ctrl_b_r <= mdb_pkg::RESET_VALUE;
			ctrl_c_r <= mdb_pkg::RESET_VALUE;
			ctrl_d_r <= mdb_pkg::RESET_VALUE;
		end
		else
		begin
			ctrl_a_r <= ctrl_a_nxt;
			ctrl_b_r <= ctrl_b_nxt;
			ctrl_c_r <= ctrl_c_nxt;
			ctrl_d_r <= ctrl_d_nxt;
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	logic [mdb_pkg::DATA_W-1:0] rd_data_r;
	logic [mdb_pkg::DATA_W-1:0] rd_data_nxt;

	// answer one cycle after the strobe, zero in every other cycle while ce is high; ce low holds the last value
	// unlisted bits and unmapped addresses read zero
	always_comb
	begin
		rd_data_nxt = rd_data_r;
		if (ce)
		begin
			rd_data_nxt = mdb_pkg::UNMAPPED_READ;
			if (rd_stb)
			begin
				unique case (addr)
					mdb_pkg::ADDR_CTRL_A: rd_data_nxt = ctrl_a_r;
					mdb_pkg::ADDR_CTRL_B: rd_data_nxt = ctrl_b_r;
					mdb_pkg::ADDR_CTRL_C: rd_data_nxt = ctrl_c_r;
					mdb_pkg::ADDR_CTRL_D: rd_data_nxt = ctrl_d_r;
					default: rd_data_nxt = mdb_pkg::UNMAPPED_READ;
				endcase
			end
		end
	end

	// read data register
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			rd_data_r <= mdb_pkg::UNMAPPED_READ;
		else
			rd_data_r <= rd_data_nxt;
	end

	assign rd_data = rd_data_r;

	// ------------------------------------------------------------
	// enable generation
	// ------------------------------------------------------------
	localparam logic [mdb_pkg::EN_W-1:0] EN_MASK = {mdb_pkg::MASK_D, mdb_pkg::MASK_C, mdb_pkg::MASK_B, MASK_A};
	logic [mdb_pkg::EN_W-1:0] en_raw;
	logic [mdb_pkg::EN_W-1:0] en_stage_q;
	logic [mdb_pkg::EN_W-1:0] en_q;

	// enable is the inverse of the disable bit
	// an absent unit stays disabled whatever the bit says
	assign en_raw = ~{ctrl_d_r, ctrl_c_r, ctrl_b_r, ctrl_a_r} & EN_MASK;

	mdb_en_stage #(
		.WIDTH(mdb_pkg::EN_W),
		.STAGES(mdb_pkg::INSTR_CYCLE_CLKS)
	) u_en_stage (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.en_in(en_raw),
		.en_out(en_stage_q)
	);

	// stage resets to all ones, so absent units are masked again here
	assign en_q = en_stage_q & EN_MASK;

	// enables gate clocks and register access downstream
	// enables of every unit, picked by register lsb and bit position
	assign timer_five_en = en_q[mdb_pkg::LSB_A + mdb_pkg::TIMER_FIVE_OFF];
	assign timer_four_en = en_q[mdb_pkg::LSB_A + mdb_pkg::TIMER_FOUR_OFF];
	assign timer_three_en = en_q[mdb_pkg::LSB_A + mdb_pkg::TIMER_THREE_OFF];
	assign timer_two_en = en_q[mdb_pkg::LSB_A + mdb_pkg::TIMER_TWO_OFF];
	assign timer_one_en = en_q[mdb_pkg::LSB_A + mdb_pkg::TIMER_ONE_OFF];
	assign quad_decoder_en = en_q[mdb_pkg::LSB_A + mdb_pkg::QUAD_DECODER_OFF];
	assign motor_pwm_en = en_q[mdb_pkg::LSB_A + mdb_pkg::MOTOR_PWM_OFF];
	assign i2c_first_en = en_q[mdb_pkg::LSB_A + mdb_pkg::I2C_FIRST_OFF];
	assign uart_second_en = en_q[mdb_pkg::LSB_A + mdb_pkg::UART_SECOND_OFF];
	assign uart_first_en = en_q[mdb_pkg::LSB_A + mdb_pkg::UART_FIRST_OFF];
	assign spi_second_en = en_q[mdb_pkg::LSB_A + mdb_pkg::SPI_SECOND_OFF];
	assign spi_first_en = en_q[mdb_pkg::LSB_A + mdb_pkg::SPI_FIRST_OFF];
	assign can_ctrl_en = en_q[mdb_pkg::LSB_A + mdb_pkg::CAN_CTRL_OFF];
	assign adc_en = en_q[mdb_pkg::LSB_A + mdb_pkg::ADC_OFF];
	assign capture_four_en = en_q[mdb_pkg::LSB_B + mdb_pkg::CAPTURE_FOUR_OFF];
	assign capture_three_en = en_q[mdb_pkg::LSB_B + mdb_pkg::CAPTURE_THREE_OFF];
	assign capture_two_en = en_q[mdb_pkg::LSB_B + mdb_pkg::CAPTURE_TWO_OFF];
	assign capture_one_en = en_q[mdb_pkg::LSB_B + mdb_pkg::CAPTURE_ONE_OFF];
	assign compare_four_en = en_q[mdb_pkg::LSB_B + mdb_pkg::COMPARE_FOUR_OFF];
	assign compare_three_en = en_q[mdb_pkg::LSB_B + mdb_pkg::COMPARE_THREE_OFF];
	assign compare_two_en = en_q[mdb_pkg::LSB_B + mdb_pkg::COMPARE_TWO_OFF];
	assign compare_one_en = en_q[mdb_pkg::LSB_B + mdb_pkg::COMPARE_ONE_OFF];
	assign comparator_en = en_q[mdb_pkg::LSB_C + mdb_pkg::COMPARATOR_OFF];
	assign crc_engine_en = en_q[mdb_pkg::LSB_C + mdb_pkg::CRC_ENGINE_OFF];
	assign i2c_second_en = en_q[mdb_pkg::LSB_C + mdb_pkg::I2C_SECOND_OFF];
	assign ref_clock_out_en = en_q[mdb_pkg::LSB_D + mdb_pkg::REF_CLOCK_OUT_OFF];
	assign charge_time_unit_en = en_q[mdb_pkg::LSB_D + mdb_pkg::CHARGE_TIME_UNIT_OFF];

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	// released reset leaves every bit clear and every present unit on
	reset_clear_a: assert property ($rose(rst_n) |-> (ctrl_a_r | ctrl_b_r | ctrl_c_r | ctrl_d_r) == 16'h0000
		&& en_q == en_raw)
		else $error("disable bits not clear after reset");

	// a write lands with only implemented bits kept
	write_ctrl_a: assert property ((ce && wr_stb && addr == mdb_pkg::ADDR_CTRL_A)
		|=> ctrl_a_r == ($past(wr_data) & MASK_A))
		else $error("control a write not stored");

	// reserved bits of control a stay zero
	rsvd_a_zero_a: assert property (ctrl_a_r[8] == 1'b0 && ctrl_a_r[2] == 1'b0)
		else $error("reserved bit of control a set");

	// unlisted bits of b, c, d stay zero
	rsvd_bcd_zero_a: assert property (((ctrl_b_r & ~mdb_pkg::MASK_B) | (ctrl_c_r & ~mdb_pkg::MASK_C)
		| (ctrl_d_r & ~mdb_pkg::MASK_D)) == 16'h0000)
		else $error("unlisted bit set in control b, c or d");

	// read of control b returns the held value next cycle
	read_back_a: assert property ((ce && rd_stb && addr == mdb_pkg::ADDR_CTRL_B && !wr_stb)
		|=> rd_data == $past(ctrl_b_r))
		else $error("control b read back wrong");

	read_unmapped_a: assert property ((ce && rd_stb && addr > mdb_pkg::ADDR_CTRL_D)
		|=> rd_data == 16'h0000)
		else $error("unmapped read not zero");

	// comparator goes off one cycle after its bit rises
	cmp_stop_a: assert property (($rose(ctrl_c_r[10]) && ce) |=> !comparator_en)
		else $error("comparator disable timing wrong");

	// timer five enable lags its bit by one cycle
	enable_lag_a: assert property ($past(ce) |-> timer_five_en == !$past(ctrl_a_r[15]))
		else $error("timer five enable lag wrong");

	// can enable follows its bit when present, stays off when absent
	can_enable_a: assert property ($past(ce) |-> can_ctrl_en == (HAS_CAN && !$past(ctrl_a_r[1])))
		else $error("can controller enable wrong");

	// reference clock output stops one cycle after its bit rises
	refclk_off_a: assert property (($rose(ctrl_d_r[3]) && ce) |=> !ref_clock_out_en)
		else $error("reference clock output not stopped");

	// main scenarios
	wr_a_c: cover property (ce && wr_stb && addr == mdb_pkg::ADDR_CTRL_A);
	rd_c_c: cover property (ce && rd_stb && addr == mdb_pkg::ADDR_CTRL_C);
	off_on_c: cover property ($fell(adc_en) ##[1:20] $rose(adc_en));
	freeze_c: cover property (!ce && wr_stb);

endmodule : mdb_bank

// file: tb/mdb_periph_model.sv
// behavioural model of the gated peripherals behind the enables
`timescale 1ns/10ps
module mdb_periph_model #(
	parameter int unsigned WIDTH = 64
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// enables from the disable bank, active high
	input wire logic [WIDTH-1:0] en,
	// one activity flop per peripheral
	output logic [WIDTH-1:0] tog
);
	logic [WIDTH-1:0] tog_r;
	logic [WIDTH-1:0] tog_nxt;

	// ------------------------------------------------------------
	// gated activity
	// ------------------------------------------------------------
	// clocked only while enabled
	// a stopped clock leaves the flop frozen, so any leak shows as a toggle
	always_comb
	begin
		tog_nxt = tog_r ^ en;
	end

	// registers only
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			tog_r <= '0;
		else
			tog_r <= tog_nxt;
	end

	assign tog = tog_r;
endmodule : mdb_periph_model

// file: tb/peripheral_module_disable_test.sv
// self-checking bench for the peripheral module disable bank
`timescale 1ns/10ps
module peripheral_module_disable_test;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic mclk;
	logic rst_n;
	logic ce;
	logic [mdb_pkg::ADDR_W-1:0] addr;
	logic [mdb_pkg::DATA_W-1:0] wr_data;
	logic wr_stb;
	logic rd_stb;
	logic [mdb_pkg::DATA_W-1:0] rd_data;
	logic timer_five_en, timer_four_en, timer_three_en, timer_two_en, timer_one_en;
	logic quad_decoder_en, motor_pwm_en, i2c_first_en, uart_second_en, uart_first_en;
	logic spi_second_en, spi_first_en, can_ctrl_en, i2c_second_en, adc_en, comparator_en;
	logic crc_engine_en, ref_clock_out_en, charge_time_unit_en;
	logic capture_four_en, capture_three_en, capture_two_en, capture_one_en;
	logic compare_four_en, compare_three_en, compare_two_en, compare_one_en;
	logic [63:0] en_v;
	logic [63:0] tog;
	logic [63:0] tog_prev;
	logic [15:0] sh [4];
	int n_mismatch;
	int comparisons;
	// implemented bits of each register, from the bit layout
	localparam logic [15:0] IMPL [4] = '{16'hFEFB, 16'h0F0F, 16'h0482, 16'h000C};

	// enables laid out like the registers; empty places read as enabled
	assign en_v = {12'hFFF, ref_clock_out_en, charge_time_unit_en, 2'h3,
		5'h1F, comparator_en, 2'h3, crc_engine_en, 5'h1F, i2c_second_en, 1'h1,
		4'hF, capture_four_en, capture_three_en, capture_two_en, capture_one_en, 4'hF,
		compare_four_en, compare_three_en, compare_two_en, compare_one_en,
		timer_five_en, timer_four_en, timer_three_en, timer_two_en, timer_one_en, quad_decoder_en,
		motor_pwm_en, 1'h1, i2c_first_en, uart_second_en, uart_first_en, spi_second_en, spi_first_en,
		1'h1, can_ctrl_en, adc_en};

	// ------------------------------------------------------------
	// design and far side
	// ------------------------------------------------------------
	mdb_bank #(.HAS_MOTOR_CTRL(1'b1), .HAS_CAN(1'b1)) uut (
		.mclk(mclk), .rst_n(rst_n), .ce(ce), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rd_data(rd_data), .timer_five_en(timer_five_en), .timer_four_en(timer_four_en),
		.timer_three_en(timer_three_en), .timer_two_en(timer_two_en), .timer_one_en(timer_one_en),
		.quad_decoder_en(quad_decoder_en), .motor_pwm_en(motor_pwm_en), .i2c_first_en(i2c_first_en),
		.uart_second_en(uart_second_en), .uart_first_en(uart_first_en), .spi_second_en(spi_second_en),
		.spi_first_en(spi_first_en), .can_ctrl_en(can_ctrl_en), .i2c_second_en(i2c_second_en),
		.adc_en(adc_en), .comparator_en(comparator_en), .crc_engine_en(crc_engine_en),
		.ref_clock_out_en(ref_clock_out_en), .charge_time_unit_en(charge_time_unit_en),
		.capture_four_en(capture_four_en), .capture_three_en(capture_three_en),
		.capture_two_en(capture_two_en), .capture_one_en(capture_one_en),
		.compare_four_en(compare_four_en), .compare_three_en(compare_three_en),
		.compare_two_en(compare_two_en), .compare_one_en(compare_one_en)
	);

	mdb_periph_model #(.WIDTH(64)) peers (.mclk(mclk), .rst_n(rst_n), .en(en_v), .tog(tog));

	// 50 MHz clock
	always #10 mclk = ~mclk;

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] expv);
		comparisons++;
		if (seen !== expv)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, expv);
		end
	endtask : check

	// expected enables are the inverse of the stored disables
	function automatic logic [63:0] exp_en();
		return ~{sh[3], sh[2], sh[1], sh[0]};
	endfunction : exp_en

	// one-cycle write; shadow follows only mapped, clocked writes
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
		if (a < 4'h4 && ce)
			sh[a[1:0]] = d & IMPL[a[1:0]];
	endtask : wr

	// one-cycle read; data looked at in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [15:0] expv);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1;
		check({48'h0, rd_data}, {48'h0, expv});
	endtask : rd

	task automatic finish_test();
		$display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	// hang guard
	initial
	begin
		#1000000;
		n_mismatch++;
		finish_test();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		rst_n = 1'b0;
		ce = 1'b1;
		addr = 4'h0;
		wr_data = 16'h0000;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		n_mismatch = 0;
		comparisons = 0;
		for (int i = 0; i < 4; i++) sh[i] = 16'h0000;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		#1;
		check(en_v, {64{1'b1}});
		for (int i = 0; i < 4; i++) rd(i[3:0], 16'h0000);
		// walk a single one through every bit, then fill each register
		for (int r = 0; r < 4; r++)
		begin
			for (int b = 0; b < 16; b++)
			begin
				wr(r[3:0], 16'h0001 << b);
				rd(r[3:0], sh[r]);
				check(en_v, exp_en());
			end
			wr(r[3:0], 16'hFFFF);
			rd(r[3:0], IMPL[r]);
			check(en_v, exp_en());
		end
		// every disabled peripheral must stay frozen, enabled places keep running
		tog_prev = tog;
		@(posedge mclk);
		#1;
		check(tog ^ tog_prev, exp_en());
		// enable follows its bit one cycle late, in both directions
		for (int k = 0; k < 2; k++)
		begin
			wr(4'h2, k ? 16'h0482 : 16'h0080);
			#1;
			check(comparator_en, k[0]);
			@(posedge mclk);
			#1;
			check(comparator_en, !k[0]);
		end
		// write then read in the very next cycle
		@(posedge mclk);
		addr <= 4'h1;
		wr_data <= 16'hA5A5;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1;
		check(rd_data, 16'h0505);
		sh[1] = 16'h0505;
		check(en_v, exp_en());
		// unmapped places ignore writes and read zero
		wr(4'h4, 16'hFFFF);
		rd(4'h4, 16'h0000);
		wr(4'hF, 16'hFFFF);
		rd(4'hF, 16'h0000);
		check(en_v, exp_en());
		// a write with the clock enable low is dropped
		@(posedge mclk);
		ce <= 1'b0;
		wr(4'h3, 16'h0000);
		@(posedge mclk);
		ce <= 1'b1;
		rd(4'h3, 16'h000C);
		// reset in mid-run clears every disable
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) sh[i] = 16'h0000;
		#1;
		check(en_v, {64{1'b1}});
		rd(4'h0, 16'h0000);
		rd(4'h2, 16'h0000);
		finish_test();
	end
endmodule : peripheral_module_disable_test
